// [sqb_host.sv]
// Host-side link model: clock pairs, commands, address, write beats and lane masks
`timescale 1ns/100ps
module sqb_host import sqb_pkg::*; #(
    parameter int C_DLY = 5
) (
    // Output clock mode: high ties both output clocks high
    input wire logic c_tied,
    // Input and output link clocks
    output logic k_clk,
    output logic k_clk_n,
    output logic c_clk,
    output logic c_clk_n,
    // Commands, address, write beats and masks
    output logic read_sel_n,
    output logic write_sel_n,
    output logic [ADDR_W-1:0] sync_address,
    output logic [DQ_W-1:0] write_data,
    output logic [LANES-1:0] byte_lane_mask_n
);
    logic k_dly, k_dly_n;

    // Idle: clocks stand still, both ports deselected
    initial begin
        k_clk = 1'b0;
        k_clk_n = 1'b1;
        k_dly = 1'b0;
        k_dly_n = 1'b1;
        read_sel_n = 1'b1;
        write_sel_n = 1'b1;
        sync_address = 8'h00;
        write_data = 18'h00000;
        byte_lane_mask_n = 2'b11;
    end

    // Output clocks trail the input pair by a small skew, or sit high
    always @(k_clk) k_dly <= #C_DLY k_clk;
    always @(k_clk_n) k_dly_n <= #C_DLY k_clk_n;
    assign c_clk = c_tied ? 1'b1 : k_dly;
    assign c_clk_n = c_tied ? 1'b1 : k_dly_n;

    // One input clock period; command changes land half a phase from a K edge, the hold-over change a quarter phase after K falls
    task automatic cycle(input logic rd_n, input logic wr_n, input logic [ADDR_W-1:0] ra,
        input logic [ADDR_W-1:0] wa, input logic [DQ_W-1:0] d0, input logic [DQ_W-1:0] d1,
        input logic [LANES-1:0] m0, input logic [LANES-1:0] m1);
        read_sel_n = rd_n;
        write_sel_n = wr_n;
        sync_address = ra;
        write_data = d0;
        byte_lane_mask_n = m0;
        #40;
        k_clk = 1'b1;
        k_clk_n = 1'b0;
        #40;
        // Selects only count at K, so they flip rather than linger
        read_sel_n = ~rd_n;
        write_sel_n = ~wr_n;
        sync_address = wa;
        write_data = d1;
        byte_lane_mask_n = m1;
        #40;
        k_clk = 1'b0;
        k_clk_n = 1'b1;
        #20;
        // Hold over: show a changed pattern, never the stale beat
        sync_address = ~wa;
        write_data = ~d1;
        #20;
    endtask : cycle
endmodule : sqb_host

// [sqb_mem.sv]
// Lane-masked storage array with registered read data
`timescale 1ns/100ps
module sqb_mem import sqb_pkg::*; (
    // Clock
    input wire logic clock,
    // Write side
    input wire logic we,
    input wire sqb_wr_s wr,
    // Read side
    input wire logic re,
    input wire logic [ADDR_W-1:0] raddr,
    output logic [WORD_W-1:0] rdata_q
);

    // One array per lane, so each array has a single writing process; unenabled lanes keep old contents
    genvar g;
    generate
        for (g = 0; g < BE_W; g++) begin : g_lane
            logic [LANE_W-1:0] lane_q [0:(1 << ADDR_W)-1];

            // Lane write and registered lane read
            always_ff @(posedge clock) begin
                if (we && wr.be[g]) begin
                    lane_q[wr.addr] <= wr.data[g*LANE_W +: LANE_W];
                end
                if (re) begin
                    rdata_q[g*LANE_W +: LANE_W] <= lane_q[raddr];
                end
            end
        end
    endgenerate

endmodule : sqb_mem

// [sqb_pkg.sv]
// Shared constants, carriers and helpers for the burst-of-two separate-I/O SRAM port
package sqb_pkg;

    // Data path geometry, set for the 18-bit variant
    localparam int DQ_W = 18;
    localparam int LANE_W = 9;
    localparam int LANES = DQ_W / LANE_W;
    localparam int WORD_W = 2 * DQ_W;
    localparam int BE_W = 2 * LANES;
    localparam int ADDR_W = 8;

    // System clock and derived counts
    localparam int CLK_NS = 20;
    localparam int OCLK_HOLD_NS = 480;
    localparam int OCLK_HOLD_CYC = (OCLK_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int OCLK_CNT_W = 6;

    // Impedance stepping
    localparam int ZQ_PERIOD_CYC = 32768;
    localparam int ZQ_CNT_W = 16;
    localparam int ZQ_CODE_W = 5;
    localparam logic [ZQ_CODE_W-1:0] ZQ_CODE_RST = 5'h10;

    // Pins as seen after the two-flop synchroniser
    typedef struct packed {
        logic k;
        logic k_n;
        logic c;
        logic c_n;
        logic rd_n;
        logic wr_n;
        logic [ADDR_W-1:0] addr;
        logic [DQ_W-1:0] d;
        logic [LANES-1:0] mask_n;
        logic zq_high;
    } sqb_pins_s;

    // One committed double-width array write
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
        logic [BE_W-1:0] be;
    } sqb_wr_s;

    // Active-low lane masks to lane enables
    function automatic logic [LANES-1:0] sqb_lane_en(input logic [LANES-1:0] mask_n);
        return ~mask_n;
    endfunction : sqb_lane_en

endpackage : sqb_pkg

// [sqb_port.sv]
// Burst-of-two DDR separate-I/O SRAM port: capture, write merge, read pipeline, output launch
`timescale 1ns/100ps
// Function
// - Address and read select sampled on every rising true input clock edge.
// - Read select low starts a read; high deselects and outputs stay Hi-Z.
// - First beat one and a half cycles after load, second beat two cycles after.
// - Beat one on complement output clock after next K; beat two on true after.
// - Output clocks held high: launch from the input clock pair instead.
// - Toggling output clocks time the output registers, allowing a delayed launch.
// - Write select sampled on true edge; write address on following complement edge.
// - Host gives beat one with the write command, beat two with the address.
// - Write select high deselects the write port; data and masks ignored.
// - Each lane mask sampled with its beat; high mask keeps stored lane unchanged.
// - Each write address is the base of a two-beat, lane-maskable transfer.
// - Masks decide per beat; all masks high aborts the whole write.
// - Four-lane variant: mask n gates nine-bit lane n, in order.
// - Eight-bit variant masks four-bit nybbles with identical sampling and abort.
// - Read and write commands accepted together in one cycle, independently.
// - A read after a completed write to the same address returns new data.
// - Same address read and written in one cycle: read forwards incoming write.
// - Free-running counter triggers impedance evaluation; one step per evaluation.
// - Eight-bit variant: nybble mask 0 gates bits 0-3, mask 1 bits 4-7.
module sqb_port import sqb_pkg::*; #(
    parameter int ZQ_PERIOD = ZQ_PERIOD_CYC
) (
    // System clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Input and output link clocks
    input wire logic k_clk,
    input wire logic k_clk_n,
    input wire logic c_clk,
    input wire logic c_clk_n,
    // Commands and address
    input wire logic read_sel_n,
    input wire logic write_sel_n,
    input wire logic [ADDR_W-1:0] sync_address,
    // Write data and masks
    input wire logic [DQ_W-1:0] write_data,
    input wire logic [LANES-1:0] byte_lane_mask_n,
    // Impedance comparator
    input wire logic impedance_ref_pin,
    // Read data pins
    output logic [DQ_W-1:0] read_data,
    output logic read_data_oe,
    // Driver impedance setting
    output logic [ZQ_CODE_W-1:0] drive_code
);

    typedef enum logic [2:0] {RD_IDLE, RD_WAIT_KN, RD_COMMIT, RD_FETCH, RD_DATA} sqb_rd_e;

    // Synchroniser and edge detect
    sqb_pins_s pins_raw;
    sqb_pins_s pins_s1_q;
    sqb_pins_s pins_s2_q;
    logic [3:0] clk_s3_q, clk_s3_d;
    logic k_rise, kn_rise, c_rise, cn_rise;

    // Write path
    logic wr_act_q, wr_act_d;
    logic [DQ_W-1:0] wr_beat0_q, wr_beat0_d;
    logic [LANES-1:0] wr_en0_q, wr_en0_d;
    sqb_wr_s mem_wr_q, mem_wr_d;
    logic mem_we_q, mem_we_d;

    // Read path
    sqb_rd_e rd_st_q, rd_st_d;
    logic [ADDR_W-1:0] rd_addr_q, rd_addr_d;
    logic [WORD_W-1:0] rd_word_q, rd_word_d;
    logic rd_valid_q, rd_valid_d;
    logic mem_re;
    logic [WORD_W-1:0] mem_rdata;

    // Output launch
    logic [WORD_W-1:0] out_word_q, out_word_d;
    logic arm0_q, arm0_d;
    logic arm1_q, arm1_d;
    logic slot0_q, slot0_d;
    logic slot1_q, slot1_d;
    logic kn_seen_q, kn_seen_d;
    logic [DQ_W-1:0] q_q, q_d;
    logic oe_q, oe_d;
    logic [OCLK_CNT_W-1:0] hold_cnt_q, hold_cnt_d;
    logic oclk_idle_q, oclk_idle_d;
    logic launch0, launch1;

    // Gather pins in struct field order; everything from outside except clock and resetn crosses two flops before use
    always_comb begin
        pins_raw = {k_clk, k_clk_n, c_clk, c_clk_n, read_sel_n, write_sel_n, sync_address, write_data,
            byte_lane_mask_n, impedance_ref_pin};
        clk_s3_d = {pins_s2_q.k, pins_s2_q.k_n, pins_s2_q.c, pins_s2_q.c_n};
    end

    // Same depth for clocks and data keeps them aligned to each other
    always_ff @(posedge clock) begin
        pins_s1_q <= pins_raw;
        pins_s2_q <= pins_s1_q;
        clk_s3_q <= clk_s3_d;
    end

    // Rising edges seen on the synchronised link clocks
    assign k_rise = pins_s2_q.k & ~clk_s3_q[3];
    assign kn_rise = pins_s2_q.k_n & ~clk_s3_q[2];
    assign c_rise = pins_s2_q.c & ~clk_s3_q[1];
    assign cn_rise = pins_s2_q.c_n & ~clk_s3_q[0];

    // Write port: command and beat one on K, address and beat two on K-bar
    always_comb begin
        wr_act_d = wr_act_q;
        wr_beat0_d = wr_beat0_q;
        wr_en0_d = wr_en0_q;
        mem_wr_d = mem_wr_q;
        mem_we_d = 1'b0;
        if (k_rise) begin
            wr_act_d = ~pins_s2_q.wr_n;
            if (!pins_s2_q.wr_n) begin
                wr_beat0_d = pins_s2_q.d;
                wr_en0_d = sqb_lane_en(pins_s2_q.mask_n);
            end
        end else if (kn_rise && wr_act_q) begin
            wr_act_d = 1'b0;
            mem_wr_d.addr = pins_s2_q.addr;
            mem_wr_d.data = {pins_s2_q.d, wr_beat0_q};
            mem_wr_d.be = {sqb_lane_en(pins_s2_q.mask_n), wr_en0_q};
            mem_we_d = |mem_wr_d.be;
        end
    end

    // Write registers
    always_ff @(posedge clock) begin
        if (!resetn) begin
            wr_act_q <= 1'b0;
            wr_beat0_q <= '0;
            wr_en0_q <= '0;
            mem_wr_q <= '0;
            mem_we_q <= 1'b0;
        end else begin
            wr_act_q <= wr_act_d;
            wr_beat0_q <= wr_beat0_d;
            wr_en0_q <= wr_en0_d;
            mem_wr_q <= mem_wr_d;
            mem_we_q <= mem_we_d;
        end
    end

    // Read port: fetch only after this cycle's write lands, so the read sees it
    always_comb begin
        rd_st_d = rd_st_q;
        rd_addr_d = rd_addr_q;
        rd_word_d = rd_word_q;
        rd_valid_d = rd_valid_q;
        mem_re = 1'b0;
        if (k_rise) begin
            rd_valid_d = 1'b0;
            if (!pins_s2_q.rd_n) begin
                rd_addr_d = pins_s2_q.addr;
                rd_st_d = RD_WAIT_KN;
            end else begin
                rd_st_d = RD_IDLE;
            end
        end else begin
            unique case (rd_st_q)
                RD_IDLE: begin
                end
                RD_WAIT_KN: begin
                    if (kn_rise) begin
                        rd_st_d = RD_COMMIT;
                    end
                end
                RD_COMMIT: begin
                    rd_st_d = RD_FETCH;
                end
                RD_FETCH: begin
                    mem_re = 1'b1;
                    rd_st_d = RD_DATA;
                end
                RD_DATA: begin
                    rd_word_d = mem_rdata;
                    rd_valid_d = 1'b1;
                    rd_st_d = RD_IDLE;
                end
            endcase
        end
    end

    // Read registers
    always_ff @(posedge clock) begin
        if (!resetn) begin
            rd_st_q <= RD_IDLE;
            rd_addr_q <= '0;
            rd_word_q <= '0;
            rd_valid_q <= 1'b0;
        end else begin
            rd_st_q <= rd_st_d;
            rd_addr_q <= rd_addr_d;
            rd_word_q <= rd_word_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    // Launch edges: C pair when toggling, K pair when both held high
    assign launch0 = slot0_q & (oclk_idle_q ? kn_rise : cn_rise);
    assign launch1 = slot1_q & kn_seen_q & (oclk_idle_q ? k_rise : c_rise);

    // Output stage; oe stays up between beats and drops at a deselected slot
    always_comb begin
        hold_cnt_d = hold_cnt_q;
        if (!(pins_s2_q.c && pins_s2_q.c_n)) begin
            hold_cnt_d = '0;
        end else if (hold_cnt_q != OCLK_CNT_W'(OCLK_HOLD_CYC)) begin
            hold_cnt_d = hold_cnt_q + 1'b1;
        end
        oclk_idle_d = (hold_cnt_q == OCLK_CNT_W'(OCLK_HOLD_CYC));
        out_word_d = out_word_q;
        arm0_d = arm0_q;
        arm1_d = arm1_q;
        slot0_d = slot0_q;
        slot1_d = slot1_q;
        kn_seen_d = kn_seen_q;
        q_d = q_q;
        oe_d = oe_q;
        if (kn_rise) begin
            kn_seen_d = 1'b1;
        end
        if (launch1) begin
            slot1_d = 1'b0;
            if (arm1_q) begin
                q_d = out_word_q[WORD_W-1 -: DQ_W];
                arm1_d = 1'b0;
            end
        end
        if (k_rise) begin
            out_word_d = rd_word_q;
            arm0_d = rd_valid_q;
            slot0_d = 1'b1;
            kn_seen_d = 1'b0;
        end else if (launch0) begin
            slot0_d = 1'b0;
            slot1_d = 1'b1;
            arm0_d = 1'b0;
            arm1_d = arm0_q;
            oe_d = arm0_q;
            if (arm0_q) begin
                q_d = out_word_q[DQ_W-1:0];
            end
        end
    end

    // Output registers
    always_ff @(posedge clock) begin
        if (!resetn) begin
            hold_cnt_q <= '0;
            oclk_idle_q <= 1'b0;
            out_word_q <= '0;
            arm0_q <= 1'b0;
            arm1_q <= 1'b0;
            slot0_q <= 1'b0;
            slot1_q <= 1'b0;
            kn_seen_q <= 1'b0;
            q_q <= '0;
            oe_q <= 1'b0;
        end else begin
            hold_cnt_q <= hold_cnt_d;
            oclk_idle_q <= oclk_idle_d;
            out_word_q <= out_word_d;
            arm0_q <= arm0_d;
            arm1_q <= arm1_d;
            slot0_q <= slot0_d;
            slot1_q <= slot1_d;
            kn_seen_q <= kn_seen_d;
            q_q <= q_d;
            oe_q <= oe_d;
        end
    end

    assign read_data = q_q;
    assign read_data_oe = oe_q;

    // Storage array
    sqb_mem u_mem (
        .clock(clock),
        .we(mem_we_q),
        .wr(mem_wr_q),
        .re(mem_re),
        .raddr(rd_addr_q),
        .rdata_q(mem_rdata)
    );

    // Impedance stepping
    sqb_zq #(.PERIOD_CYC(ZQ_PERIOD)) u_zq (
        .clock(clock),
        .resetn(resetn),
        .zq_high(pins_s2_q.zq_high),
        .code_q(drive_code)
    );

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_read_load;
        k_rise && !pins_s2_q.rd_n;
    endsequence
    sequence s_write_load;
        k_rise && !pins_s2_q.wr_n;
    endsequence

    a_read_capture: assert property (s_read_load |=> rd_addr_q == $past(pins_s2_q.addr))
        else $error("read address not captured on K");
    a_read_deselect: assert property (launch0 && !arm0_q |=> !read_data_oe)
        else $error("output driven in a deselected slot");
    a_beat0_launch: assert property (launch0 && arm0_q |=>
        read_data_oe && read_data == $past(out_word_q[DQ_W-1:0]))
        else $error("first read beat wrong");
    a_beat1_launch: assert property (launch1 && arm1_q |=>
        read_data == $past(out_word_q[WORD_W-1 -: DQ_W]))
        else $error("second read beat wrong");
    a_k_mode_launch: assert property (oclk_idle_q && slot0_q && arm0_q && kn_rise |=>
        read_data_oe && read_data == $past(out_word_q[DQ_W-1:0]))
        else $error("K-bar did not launch with output clocks held");
    a_write_hold: assert property (s_write_load |=> wr_act_q && wr_beat0_q == $past(pins_s2_q.d))
        else $error("write beat one not held");
    a_write_deselect: assert property (k_rise && pins_s2_q.wr_n |=> !wr_act_q [*3])
        else $error("deselected write still active");
    a_write_commit: assert property (mem_we_q |-> $past(kn_rise && wr_act_q) && mem_wr_q.be != '0)
        else $error("array write without its second beat");
    a_read_after_write: assert property (rd_st_q == RD_FETCH |-> !mem_we_q && !wr_act_q)
        else $error("read fetched before pending write landed");

endmodule : sqb_port

// [sqb_port_tb_top.sv]
// Self-checking bench: traffic in both output clock modes, masks, pass-through, impedance stepping
`timescale 1ns/100ps
module sqb_port_tb_top import sqb_pkg::*; ;
    localparam int ZQ_TB_PERIOD = 16;
    logic clock, resetn, impedance_ref_pin, c_tied;
    logic k_clk, k_clk_n, c_clk, c_clk_n, read_sel_n, write_sel_n, read_data_oe;
    logic [ADDR_W-1:0] sync_address;
    logic [DQ_W-1:0] write_data, read_data;
    logic [LANES-1:0] byte_lane_mask_n;
    logic [ZQ_CODE_W-1:0] drive_code;
    logic [WORD_W-1:0] mem [2**ADDR_W];
    logic exp_rd [$];
    logic [WORD_W-1:0] exp_word [$];
    int fail_count, tests_run, seed;

    // Port under test, impedance period shortened
    sqb_port #(.ZQ_PERIOD(ZQ_TB_PERIOD)) sqb_port_i (.clock(clock), .resetn(resetn), .k_clk(k_clk),
        .k_clk_n(k_clk_n), .c_clk(c_clk), .c_clk_n(c_clk_n), .read_sel_n(read_sel_n),
        .write_sel_n(write_sel_n), .sync_address(sync_address), .write_data(write_data),
        .byte_lane_mask_n(byte_lane_mask_n), .impedance_ref_pin(impedance_ref_pin),
        .read_data(read_data), .read_data_oe(read_data_oe), .drive_code(drive_code));

    // Host controller model
    sqb_host #(.C_DLY(5)) sqb_host_i (.c_tied(c_tied), .k_clk(k_clk), .k_clk_n(k_clk_n), .c_clk(c_clk),
        .c_clk_n(c_clk_n), .read_sel_n(read_sel_n), .write_sel_n(write_sel_n), .sync_address(sync_address),
        .write_data(write_data), .byte_lane_mask_n(byte_lane_mask_n));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // Expected word after a two-beat write; a high mask keeps the old lane
    function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] old, input logic [DQ_W-1:0] d0,
        input logic [DQ_W-1:0] d1, input logic [LANES-1:0] m0, input logic [LANES-1:0] m1);
        logic [WORD_W-1:0] w;
        w = old;
        for (int l = 0; l < LANES; l++) begin
            if (!m0[l]) w[l*LANE_W +: LANE_W] = d0[l*LANE_W +: LANE_W];
            if (!m1[l]) w[DQ_W + l*LANE_W +: LANE_W] = d1[l*LANE_W +: LANE_W];
        end
        return w;
    endfunction : merge

    function automatic logic [DQ_W-1:0] rand_beat();
        logic [31:0] r;
        r = $random(seed);
        return r[DQ_W-1:0];
    endfunction : rand_beat

    // One link cycle; checks both beats of the read loaded two cycles back
    task automatic link_cycle(input logic rd_n, input logic wr_n, input logic [ADDR_W-1:0] ra,
        input logic [ADDR_W-1:0] wa, input logic [DQ_W-1:0] d0, input logic [DQ_W-1:0] d1,
        input logic [LANES-1:0] m0, input logic [LANES-1:0] m1);
        logic rd_old;
        logic [WORD_W-1:0] w_old;
        // Write lands before the read fetch, so a same-address read sees it
        if (!wr_n) mem[wa] = merge(mem[wa], d0, d1, m0, m1);
        exp_rd.push_back(!rd_n);
        exp_word.push_back(mem[ra]);
        fork
            sqb_host_i.cycle(rd_n, wr_n, ra, wa, d0, d1, m0, m1);
            if (exp_rd.size() > 2) begin
                rd_old = exp_rd.pop_front();
                w_old = exp_word.pop_front();
                #60;
                check(read_data_oe, rd_old);
                if (rd_old) check(read_data, w_old[DQ_W-1:0]);
                #80;
                check(read_data_oe, rd_old);
                if (rd_old) check(read_data, w_old[WORD_W-1:DQ_W]);
            end
        join
    endtask : link_cycle

    task automatic rand_cycle;
        logic [31:0] r;
        logic [31:0] a;
        r = $random(seed);
        a = $random(seed);
        link_cycle(r[0] & r[1], r[2] & r[3], {5'h00, a[2:0]}, {5'h00, a[5:3]}, rand_beat(), rand_beat(),
            r[5:4], r[7:6]);
    endtask : rand_cycle

    task automatic run_phase;
        exp_rd.delete();
        exp_word.delete();
        @(posedge clock);
        #7;
        // Known contents first, so masked lanes have a defined old value
        for (int a = 0; a < 8; a++) link_cycle(1'b1, 1'b0, 8'h00, ADDR_W'(a), rand_beat(), rand_beat(), 2'b00, 2'b00);
        link_cycle(1'b1, 1'b0, 8'h00, 8'hff, rand_beat(), rand_beat(), 2'b00, 2'b00);
        link_cycle(1'b0, 1'b0, 8'h03, 8'h03, 18'h155aa, 18'h2aa55, 2'b10, 2'b01);
        link_cycle(1'b0, 1'b0, 8'h05, 8'h05, rand_beat(), rand_beat(), 2'b11, 2'b11);
        link_cycle(1'b0, 1'b1, 8'h04, 8'h04, rand_beat(), rand_beat(), 2'b00, 2'b00);
        link_cycle(1'b1, 1'b0, 8'h02, 8'hff, rand_beat(), rand_beat(), 2'b01, 2'b00);
        link_cycle(1'b0, 1'b1, 8'hff, 8'h06, rand_beat(), rand_beat(), 2'b00, 2'b00);
        link_cycle(1'b1, 1'b1, 8'h03, 8'h03, rand_beat(), rand_beat(), 2'b00, 2'b00);
        repeat (48) rand_cycle();
        // Two deselect cycles flush the last reads
        repeat (2) link_cycle(1'b1, 1'b1, 8'h33, 8'hcc, rand_beat(), rand_beat(), 2'b00, 2'b00);
    endtask : run_phase

    // Steady comparator level: single steps, spaced a period apart, ending saturated
    task automatic zq_run(input logic up, input int periods, input logic [ZQ_CODE_W-1:0] final_code);
        logic [ZQ_CODE_W-1:0] prev;
        int gap;
        impedance_ref_pin = up;
        prev = drive_code;
        gap = ZQ_TB_PERIOD;
        repeat (ZQ_TB_PERIOD * periods) begin
            @(posedge clock);
            #7;
            gap++;
            if (drive_code !== prev) begin
                check(drive_code, up ? prev + 5'h01 : prev - 5'h01);
                check(gap >= ZQ_TB_PERIOD, 1'b1);
                prev = drive_code;
                gap = 0;
            end
        end
        check(drive_code, final_code);
    endtask : zq_run

    // Watchdog against a hung run
    initial begin
        #400000;
        fail_count++;
        print_verdict();
    end

    initial begin
        seed = 42;
        fail_count = 0;
        tests_run = 0;
        resetn = 1'b0;
        impedance_ref_pin = 1'b1;
        c_tied = 1'b0;
        repeat (3) @(posedge clock);
        #7;
        check(read_data_oe, 1'b0);
        check(read_data, 18'h00000);
        check(drive_code, ZQ_CODE_RST);
        resetn = 1'b1;
        zq_run(1'b1, 20, 5'h1f);
        zq_run(1'b0, 40, 5'h00);
        run_phase();
        // Both output clocks high long enough to select input clock launch
        c_tied = 1'b1;
        repeat (30) @(posedge clock);
        run_phase();
        print_verdict();
    end
endmodule : sqb_port_tb_top

// [sqb_zq.sv]
// Periodic output impedance evaluation and one-step driver code update
`timescale 1ns/100ps
module sqb_zq import sqb_pkg::*; #(
    parameter int PERIOD_CYC = ZQ_PERIOD_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Synchronised comparator: driver impedance above target
    input wire logic zq_high,
    // Binary-weighted driver setting
    output logic [ZQ_CODE_W-1:0] code_q
);

    logic [ZQ_CNT_W-1:0] cnt_q;
    logic [ZQ_CNT_W-1:0] cnt_d;
    logic [ZQ_CODE_W-1:0] code_d;

    // Count, evaluate on wrap, then restart
    always_comb begin
        cnt_d = cnt_q + 1'b1;
        code_d = code_q;
        if (cnt_q == ZQ_CNT_W'(PERIOD_CYC - 1)) begin
            cnt_d = '0;
            if (zq_high && code_q != '1) begin
                code_d = code_q + 1'b1;
            end else if (!zq_high && code_q != '0) begin
                code_d = code_q - 1'b1;
            end
        end
    end

    // State registers
    always_ff @(posedge clock) begin
        if (!resetn) begin
            cnt_q <= '0;
            code_q <= ZQ_CODE_RST;
        end else begin
            cnt_q <= cnt_d;
            code_q <= code_d;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_zq_one_step: assert property ($changed(code_q) |->
        (code_q == $past(code_q) + 1'b1) || (code_q == $past(code_q) - 1'b1))
        else $error("impedance code moved more than one step");
    a_zq_on_wrap: assert property ($changed(code_q) |-> $past(cnt_q) == ZQ_CNT_W'(PERIOD_CYC - 1))
        else $error("impedance code moved outside an evaluation");

endmodule : sqb_zq
